// [pkg/serial_cfg_pkg.sv]
// Functional notes
// - At most one port is set for ASCII character traffic at a time.
// - Toggling mode with data-set-ready inactive: 8-bit ASCII characters.
// - Toggling mode with data-set-ready active: 8-bit RTU frames as slave.
// - Parent/child: one-port part toggles primary; two-port toggles secondary, primary Modbus.
// - Single mode: every point-to-point port defaults to dedicated Modbus.
// - Point-to-point ports default to 9600 baud; Modbus ports talk Modbus only.
// - Modbus ports act as slaves only; the master starts every transaction.
// - Primary Modbus: RTU only at 9600 baud, 7-bit ASCII only at 2400.
// - Primary Modbus: even parity and one stop bit, nothing else.
// - Slave address settable 1 to 247, defaults to 1.
// - Secondary Modbus: 50..19200 baud steps, ASCII7 or RTU8, any parity, 1/2 stops.
// - Primary/expansion ASCII rejects 7N1 and 8-bit two stops with parity.
// - Simple ASCII carries 7/8-bit characters only, no RTU, user program data.
// - Point-to-point simple ASCII: 1200..9600 baud, 7/8 bits, any parity, 1/2 stops.
// - Modem handshake only in dedicated Modbus mode.
// - Primary in toggling mode has no modem operation.
// - Expansion ASCII in single mode: 1200..9600 baud, 7/8 bits, any parity, 1/2 stops.
// - Parent/child expansion port uses fixed preset parameters, not configurable.
// - Secondary serves one user function; transmit_block wins over the message block.
// - Single mode expansion port: ASCII or disabled, defaults to ASCII.
package serial_cfg_pkg;

  typedef enum logic [1:0] {OP_SINGLE, OP_PARENT, OP_CHILD} op_mode_t;
  typedef enum logic [2:0] {PM_MODBUS, PM_ASCII, PM_TOGGLE, PM_DISABLED, PM_EXPLINK} port_mode_t;

  localparam int NUM_PORTS = 3;
  localparam logic [1:0] PORT_PRI = 2'h0;
  localparam logic [1:0] PORT_SEC = 2'h1;
  localparam logic [1:0] PORT_EXP = 2'h2;

  // baud step codes, ascending
  localparam logic [3:0] BAUD_50 = 4'h0;
  localparam logic [3:0] BAUD_1200 = 4'h7;
  localparam logic [3:0] BAUD_2400 = 4'ha;
  localparam logic [3:0] BAUD_4800 = 4'hc;
  localparam logic [3:0] BAUD_9600 = 4'he;
  localparam logic [3:0] BAUD_19200 = 4'hf;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_BAD = 2'h3;

  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;

  localparam logic [3:0] DEF_BAUD = BAUD_9600;
  localparam logic [1:0] DEF_MODBUS_PARITY = PAR_EVEN;
  localparam logic [1:0] DEF_ASCII_PARITY = PAR_NONE;

  // expansion link preset framing; fixed, not the port defaults
  localparam logic [3:0] EXP_PRESET_BAUD = BAUD_19200;
  localparam logic [1:0] EXP_PRESET_PARITY = PAR_NONE;
  localparam logic EXP_PRESET_DATA8 = 1'b1;
  localparam logic EXP_PRESET_STOP2 = 1'b0;

  localparam int CHAR_WIDTH = 8;
  localparam int CHAR_FIFO_DEPTH = 16;
  localparam logic [7:0] CHAR7_MASK = 8'h7f;

endpackage : serial_cfg_pkg

// [rtl/char_fifo.sv]
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic in_valid, // writer has a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // reader takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } fifo_state_t;

  fifo_state_t s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = in_valid && s_reg.in_ready;
  assign pop = out_ready && s_reg.out_valid;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr_ptr = (s_reg.wr_ptr == LAST_PTR) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == LAST_PTR) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    s_next.count = s_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_next.in_ready = s_next.count != FULL_COUNT;
    s_next.out_valid = s_next.count != '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      mem[s_reg.wr_ptr] <= in_data;
    end
  end

  assign in_ready = s_reg.in_ready;
  assign out_valid = s_reg.out_valid;
  assign out_data = mem[s_reg.rd_ptr];
endmodule : char_fifo

// [rtl/serial_port_mode_config.sv]
module serial_port_mode_config #(
  parameter int FIFO_DEPTH = serial_cfg_pkg::CHAR_FIFO_DEPTH,
  parameter int FIFO_WIDTH = serial_cfg_pkg::CHAR_WIDTH
) (
  input wire logic ref_clk, // system clock, 40 MHz
  input wire logic rst, // sync reset, high
  input wire serial_cfg_pkg::op_mode_t op_mode, // single, parent or child
  input wire logic two_port, // part has a secondary port
  input wire logic [1:0] dsr, // data-set-ready per point-to-point port
  input wire logic cfg_wr, // configuration write pulse
  input wire logic [1:0] cfg_port, // port written
  input wire serial_cfg_pkg::port_mode_t cfg_mode, // requested mode
  input wire logic [3:0] cfg_baud, // requested baud step
  input wire logic cfg_data8, // 8 data bits
  input wire logic cfg_rtu, // RTU framing
  input wire logic [1:0] cfg_parity, // parity code
  input wire logic cfg_stop2, // two stop bits
  input wire logic [7:0] cfg_addr, // slave address
  output logic cfg_ack, // write accepted
  output logic cfg_err, // write refused
  output logic [2:0] port_on, // port enabled
  output logic [2:0][3:0] port_baud, // active baud step
  output logic [2:0] port_rtu, // RTU framing active
  output logic [2:0] port_data8, // 8 data bits
  output logic [2:0][1:0] port_parity, // active parity
  output logic [2:0] port_stop2, // two stop bits
  output logic [2:0][7:0] port_addr, // slave address
  output logic [2:0] modem_en, // modem handshake enabled
  output logic [2:0] slave_resp, // port answers a master
  input wire logic transmit_block_req, // transmit_block active on secondary
  input wire logic msg_req, // ASCII message block active on secondary
  output logic transmit_block_grant, // transmit_block owns secondary
  output logic msg_grant, // message block owns secondary
  input wire logic char_in_valid, // user program character
  input wire logic [7:0] char_in_data, // character written
  output logic char_in_ready, // character buffer has room
  output logic char_valid, // character for the ASCII port
  output logic [7:0] char_data, // character, masked to width
  output logic [1:0] char_port, // which port carries it
  input wire logic char_ready // serializer takes character
);
  typedef struct packed {
    serial_cfg_pkg::op_mode_t op_mode;
    logic loaded;
    serial_cfg_pkg::port_mode_t [2:0] mode;
    logic [2:0][3:0] baud;
    logic [2:0] data8;
    logic [2:0] rtu;
    logic [2:0][1:0] parity;
    logic [2:0] stop2;
    logic [2:0][7:0] addr;
    logic cfg_ack;
    logic cfg_err;
    logic [2:0] on;
    logic [2:0][3:0] e_baud;
    logic [2:0] e_rtu;
    logic [2:0] e_data8;
    logic [2:0][1:0] e_parity;
    logic [2:0] e_stop2;
    logic [2:0] modem;
    logic [2:0] resp;
    logic transmit_block_grant;
    logic msg_grant;
    logic char_valid;
    logic [7:0] char_data;
    logic [1:0] char_port;
  } state_t;

  state_t s_reg, s_next;
  logic fifo_valid, fifo_ready;
  logic [FIFO_WIDTH-1:0] fifo_data;

  function automatic logic ascii_frame_ok(logic [3:0] baud, logic data8, logic rtu,
                                          logic [1:0] par, logic stop2, logic strict);
    logic ok;
    ok = !rtu && par != serial_cfg_pkg::PAR_BAD;
    if (baud != serial_cfg_pkg::BAUD_1200 && baud != serial_cfg_pkg::BAUD_2400 &&
        baud != serial_cfg_pkg::BAUD_4800 && baud != serial_cfg_pkg::BAUD_9600) begin
      ok = 1'b0;
    end
    if (strict && !data8 && !stop2 && par == serial_cfg_pkg::PAR_NONE) begin
      ok = 1'b0;
    end
    if (strict && data8 && stop2 && par != serial_cfg_pkg::PAR_NONE) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : ascii_frame_ok

  function automatic logic modbus_frame_ok(logic [1:0] port, logic [3:0] baud, logic data8,
                                           logic rtu, logic [1:0] par, logic stop2, logic [7:0] addr);
    logic ok;
    ok = addr >= serial_cfg_pkg::ADDR_MIN && addr <= serial_cfg_pkg::ADDR_MAX;
    ok = ok && (data8 == rtu) && par != serial_cfg_pkg::PAR_BAD;
    if (port == serial_cfg_pkg::PORT_PRI) begin
      if (rtu && baud != serial_cfg_pkg::BAUD_9600) begin
        ok = 1'b0;
      end
      if (!rtu && baud != serial_cfg_pkg::BAUD_2400) begin
        ok = 1'b0;
      end
      if (par != serial_cfg_pkg::PAR_EVEN || stop2) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : modbus_frame_ok

  always_comb begin
    logic legal;
    logic other_ascii;
    logic ascii_live;
    logic [1:0] ascii_idx;
    logic [1:0] idx;
    legal = 1'b0;
    other_ascii = 1'b0;
    ascii_live = 1'b0;
    ascii_idx = serial_cfg_pkg::PORT_PRI;
    idx = '0;
    s_next = s_reg;
    s_next.cfg_ack = 1'b0;
    s_next.cfg_err = 1'b0;

    if (!s_reg.loaded || op_mode != s_reg.op_mode) begin
      // defaults follow the operating mode; writes in this cycle are lost and refused
      s_next.loaded = 1'b1;
      s_next.op_mode = op_mode;
      for (int p = 0; p < serial_cfg_pkg::NUM_PORTS; p++) begin
        s_next.baud[p] = serial_cfg_pkg::DEF_BAUD;
        s_next.data8[p] = 1'b1;
        s_next.rtu[p] = 1'b1;
        s_next.parity[p] = serial_cfg_pkg::DEF_MODBUS_PARITY;
        s_next.stop2[p] = 1'b0;
        s_next.addr[p] = serial_cfg_pkg::ADDR_DEFAULT;
        s_next.mode[p] = serial_cfg_pkg::PM_MODBUS;
      end
      if (op_mode == serial_cfg_pkg::OP_SINGLE) begin
        s_next.mode[serial_cfg_pkg::PORT_EXP] = serial_cfg_pkg::PM_ASCII;
        s_next.rtu[serial_cfg_pkg::PORT_EXP] = 1'b0;
        s_next.parity[serial_cfg_pkg::PORT_EXP] = serial_cfg_pkg::DEF_ASCII_PARITY;
      end else begin
        s_next.mode[serial_cfg_pkg::PORT_EXP] = serial_cfg_pkg::PM_EXPLINK;
        if (two_port) begin
          s_next.mode[serial_cfg_pkg::PORT_SEC] = serial_cfg_pkg::PM_TOGGLE;
        end else begin
          s_next.mode[serial_cfg_pkg::PORT_PRI] = serial_cfg_pkg::PM_TOGGLE;
        end
      end
      if (!two_port) begin
        s_next.mode[serial_cfg_pkg::PORT_SEC] = serial_cfg_pkg::PM_DISABLED;
      end
      if (cfg_wr) begin
        s_next.cfg_err = 1'b1;
      end
    end else if (cfg_wr) begin
      for (int p = 0; p < serial_cfg_pkg::NUM_PORTS; p++) begin
        if (2'(p) != cfg_port && (s_reg.mode[p] == serial_cfg_pkg::PM_ASCII ||
                                  s_reg.mode[p] == serial_cfg_pkg::PM_TOGGLE)) begin
          other_ascii = 1'b1;
        end
      end
      unique case (cfg_mode)
        serial_cfg_pkg::PM_MODBUS: begin
          legal = cfg_port != serial_cfg_pkg::PORT_EXP &&
                  modbus_frame_ok(cfg_port, cfg_baud, cfg_data8, cfg_rtu, cfg_parity, cfg_stop2, cfg_addr);
        end
        serial_cfg_pkg::PM_ASCII: begin
          legal = !other_ascii &&
                  ascii_frame_ok(cfg_baud, cfg_data8, cfg_rtu, cfg_parity, cfg_stop2,
                                 cfg_port != serial_cfg_pkg::PORT_SEC);
        end
        serial_cfg_pkg::PM_TOGGLE: begin
          legal = !other_ascii && cfg_port != serial_cfg_pkg::PORT_EXP &&
                  cfg_parity != serial_cfg_pkg::PAR_BAD;
        end
        serial_cfg_pkg::PM_DISABLED: begin
          legal = 1'b1;
        end
        serial_cfg_pkg::PM_EXPLINK: begin
          legal = 1'b0;
        end
        default: begin
          legal = 1'b0;
        end
      endcase
      if (cfg_port == serial_cfg_pkg::PORT_EXP && s_reg.op_mode != serial_cfg_pkg::OP_SINGLE) begin
        legal = 1'b0;
      end
      if (cfg_port == serial_cfg_pkg::PORT_SEC && !two_port) begin
        legal = 1'b0;
      end
      if (cfg_port > serial_cfg_pkg::PORT_EXP) begin
        legal = 1'b0;
      end
      if (legal) begin
        s_next.mode[cfg_port] = cfg_mode;
        s_next.baud[cfg_port] = cfg_baud;
        s_next.data8[cfg_port] = cfg_data8;
        s_next.rtu[cfg_port] = cfg_rtu;
        s_next.parity[cfg_port] = cfg_parity;
        s_next.stop2[cfg_port] = cfg_stop2;
        if (cfg_mode == serial_cfg_pkg::PM_MODBUS) begin
          s_next.addr[cfg_port] = cfg_addr;
        end
      end
      s_next.cfg_ack = legal;
      s_next.cfg_err = !legal;
    end

    // one framing set per port, shared by its transmitter and receiver
    for (int p = 0; p < serial_cfg_pkg::NUM_PORTS; p++) begin
      s_next.e_baud[p] = s_reg.baud[p];
      s_next.e_parity[p] = s_reg.parity[p];
      s_next.e_stop2[p] = s_reg.stop2[p];
      s_next.e_data8[p] = s_reg.data8[p];
      s_next.e_rtu[p] = 1'b0;
      s_next.on[p] = 1'b1;
      s_next.modem[p] = 1'b0;
      s_next.resp[p] = 1'b0;
      unique case (s_reg.mode[p])
        serial_cfg_pkg::PM_MODBUS: begin
          s_next.e_rtu[p] = s_reg.rtu[p];
          s_next.modem[p] = p != int'(serial_cfg_pkg::PORT_EXP);
          s_next.resp[p] = 1'b1;
        end
        serial_cfg_pkg::PM_ASCII: begin
          s_next.e_rtu[p] = 1'b0;
        end
        serial_cfg_pkg::PM_TOGGLE: begin
          // dsr is the framing select, so modem control is unavailable
          s_next.e_data8[p] = 1'b1;
          s_next.e_rtu[p] = p < int'(serial_cfg_pkg::PORT_EXP) && dsr[p];
          s_next.resp[p] = p < int'(serial_cfg_pkg::PORT_EXP) && dsr[p];
          s_next.modem[p] = 1'b0;
        end
        serial_cfg_pkg::PM_DISABLED: begin
          s_next.on[p] = 1'b0;
        end
        serial_cfg_pkg::PM_EXPLINK: begin
          s_next.e_baud[p] = serial_cfg_pkg::EXP_PRESET_BAUD;
          s_next.e_parity[p] = serial_cfg_pkg::EXP_PRESET_PARITY;
          s_next.e_stop2[p] = serial_cfg_pkg::EXP_PRESET_STOP2;
          s_next.e_data8[p] = serial_cfg_pkg::EXP_PRESET_DATA8;
        end
        default: begin
          s_next.on[p] = 1'b0;
        end
      endcase
    end

    // secondary port serves a single user function
    s_next.transmit_block_grant = transmit_block_req && two_port;
    s_next.msg_grant = msg_req && !transmit_block_req && two_port;

    for (int p = 0; p < serial_cfg_pkg::NUM_PORTS; p++) begin
      idx = 2'(p);
      if (s_reg.mode[p] == serial_cfg_pkg::PM_ASCII ||
          (s_reg.mode[p] == serial_cfg_pkg::PM_TOGGLE && p < int'(serial_cfg_pkg::PORT_EXP) && !dsr[p])) begin
        ascii_live = 1'b1;
        ascii_idx = idx;
      end
    end
    // a held character waits while no port is in character mode
    fifo_ready = ascii_live && (!s_reg.char_valid || char_ready);
    if (fifo_ready && fifo_valid) begin
      s_next.char_valid = 1'b1;
      s_next.char_port = ascii_idx;
      s_next.char_data = s_reg.data8[ascii_idx] || s_reg.mode[ascii_idx] == serial_cfg_pkg::PM_TOGGLE ?
                         fifo_data : (fifo_data & serial_cfg_pkg::CHAR7_MASK);
    end else if (char_ready) begin
      s_next.char_valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  char_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_char_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(char_in_valid),
    .in_ready(char_in_ready),
    .in_data(char_in_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  assign cfg_ack = s_reg.cfg_ack;
  assign cfg_err = s_reg.cfg_err;
  assign port_on = s_reg.on;
  assign port_baud = s_reg.e_baud;
  assign port_rtu = s_reg.e_rtu;
  assign port_data8 = s_reg.e_data8;
  assign port_parity = s_reg.e_parity;
  assign port_stop2 = s_reg.e_stop2;
  assign port_addr = s_reg.addr;
  assign modem_en = s_reg.modem;
  assign slave_resp = s_reg.resp;
  assign transmit_block_grant = s_reg.transmit_block_grant;
  assign msg_grant = s_reg.msg_grant;
  assign char_valid = s_reg.char_valid;
  assign char_data = s_reg.char_data;
  assign char_port = s_reg.char_port;
endmodule : serial_port_mode_config

// [tb/serial_port_mode_config_sva.sv]
module serial_port_mode_config_sva (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset
  input wire serial_cfg_pkg::op_mode_t op_mode, // operating mode
  input wire logic two_port, // secondary present
  input wire logic cfg_wr, // write pulse
  input wire serial_cfg_pkg::port_mode_t cfg_mode, // requested mode
  input wire logic [7:0] cfg_addr, // requested address
  input wire logic cfg_ack, // accepted
  input wire logic cfg_err, // refused
  input wire logic [2:0][3:0] port_baud, // baud per port
  input wire logic [2:0] port_rtu, // rtu framing
  input wire logic [2:0] port_data8, // 8 data bits
  input wire logic [2:0][1:0] port_parity, // parity per port
  input wire logic [2:0] modem_en, // modem allowed
  input wire logic [2:0] slave_resp, // answers a master
  input wire logic transmit_block_req, // transmit request
  input wire logic msg_req, // message request
  input wire logic transmit_block_grant, // transmit owner
  input wire logic msg_grant, // message owner
  input wire logic char_valid, // char offered
  input wire logic [7:0] char_data, // char value
  input wire logic [1:0] char_port, // char port
  input wire logic char_ready // char taken
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  answer_once_a: assert property (cfg_wr |=> cfg_ack != cfg_err)
    else $error("config write not answered by exactly one of ack and err");
  addr_refuse_a: assert property (cfg_wr && cfg_mode == serial_cfg_pkg::PM_MODBUS &&
    (cfg_addr == 8'h00 || cfg_addr > serial_cfg_pkg::ADDR_MAX) |=> cfg_err) else $error("bad address accepted");
  modem_slave_a: assert property ((modem_en & ~slave_resp) == 3'h0 && !modem_en[2])
    else $error("modem enabled on a port that is not a slave");
  rtu_width_a: assert property ((port_rtu & ~port_data8) == 3'h0)
    else $error("rtu framing without 8 data bits");
  parity_legal_a: assert property (port_parity[0] != serial_cfg_pkg::PAR_BAD &&
    port_parity[1] != serial_cfg_pkg::PAR_BAD && port_parity[2] != serial_cfg_pkg::PAR_BAD)
    else $error("illegal parity code active");
  grant_prio_a: assert property (transmit_block_req && two_port |=> transmit_block_grant && !msg_grant)
    else $error("transmit block did not win the secondary");
  grant_msg_a: assert property (msg_req && !transmit_block_req && two_port |=> msg_grant && !transmit_block_grant)
    else $error("message block not granted when alone");
  char_hold_a: assert property (char_valid && !char_ready |=> char_valid && $stable(char_data) && $stable(char_port))
    else $error("character changed while stalled");
  char_width_a: assert property (char_valid && !port_data8[char_port] |-> !char_data[7])
    else $error("bit 7 set on a 7-bit port");
  exp_preset_a: assert property ((op_mode != serial_cfg_pkg::OP_SINGLE) [*4] |->
    port_baud[2] == serial_cfg_pkg::EXP_PRESET_BAUD) else $error("expansion baud not preset");

  cover property (cfg_err);
  cover property (char_valid && char_ready);
  cover property (transmit_block_req && msg_req ##1 transmit_block_grant);
  cover property (slave_resp[1] && !modem_en[1]);
endmodule : serial_port_mode_config_sva

bind serial_port_mode_config serial_port_mode_config_sva chk (.ref_clk, .rst, .op_mode, .two_port, .cfg_wr,
  .cfg_mode, .cfg_addr, .cfg_ack, .cfg_err, .port_baud, .port_rtu, .port_data8, .port_parity, .modem_en,
  .slave_resp, .transmit_block_req, .msg_req, .transmit_block_grant, .msg_grant, .char_valid, .char_data, .char_port, .char_ready);

// [tb/char_sink.sv]
module char_sink (
  input wire logic ref_clk, // clock
  input wire logic hold, // refuse every character
  input wire logic slow, // take characters at random
  output logic char_ready // takes a character
);
  timeunit 1ns;
  timeprecision 1ps;
  initial char_ready = 1'b0;
  // a slow sink keeps the output stage stalled on random cycles
  always @(posedge ref_clk) begin
    char_ready <= !hold && (!slow || $urandom_range(1, 0) == 1);
  end
endmodule : char_sink

// [tb/serial_port_mode_config_tb.sv]
module serial_port_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, two_port, cfg_wr, cfg_data8, cfg_rtu, cfg_stop2, transmit_block_req, msg_req, char_in_valid, hold, slow;
  logic char_ready, cfg_ack, cfg_err, char_in_ready, char_valid, transmit_block_grant, msg_grant;
  logic [1:0] dsr, cfg_port, cfg_parity, char_port;
  logic [3:0] cfg_baud;
  logic [7:0] cfg_addr, char_in_data, char_data, ra;
  logic [2:0] port_on, port_rtu, port_data8, port_stop2, modem_en, slave_resp;
  logic [2:0][3:0] port_baud;
  logic [2:0][1:0] port_parity;
  logic [2:0][7:0] port_addr;
  serial_cfg_pkg::op_mode_t op_mode;
  serial_cfg_pkg::port_mode_t cfg_mode;
  logic resp_q[$];
  logic [9:0] char_q[$];
  int num_errors = 0;
  int checked = 0;
  int n;

  serial_port_mode_config #(.FIFO_DEPTH(16), .FIFO_WIDTH(8)) dut (.ref_clk, .rst, .op_mode, .two_port, .dsr,
    .cfg_wr, .cfg_port, .cfg_mode, .cfg_baud, .cfg_data8, .cfg_rtu, .cfg_parity, .cfg_stop2, .cfg_addr, .cfg_ack,
    .cfg_err, .port_on, .port_baud, .port_rtu, .port_data8, .port_parity, .port_stop2, .port_addr, .modem_en,
    .slave_resp, .transmit_block_req, .msg_req, .transmit_block_grant, .msg_grant, .char_in_valid, .char_in_data, .char_in_ready,
    .char_valid, .char_data, .char_port, .char_ready);
  char_sink sink (.ref_clk, .hold, .slow, .char_ready);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_lvl(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_lvl

  task automatic cmp_char(input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR char expected %h seen %h", e, g);
    end
  endtask : cmp_char

  task automatic cfg(input logic [1:0] p, input logic [2:0] m, input logic [3:0] b, input logic d8, input logic rt,
                     input logic [1:0] pa, input logic s2, input logic [7:0] a, input logic ok);
    @(posedge ref_clk);
    cfg_wr <= 1'h1;
    cfg_port <= p;
    cfg_mode <= serial_cfg_pkg::port_mode_t'(m);
    cfg_baud <= b;
    cfg_data8 <= d8;
    cfg_rtu <= rt;
    cfg_parity <= pa;
    cfg_stop2 <= s2;
    cfg_addr <= a;
    resp_q.push_back(ok);
    @(posedge ref_clk);
    cfg_wr <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask : cfg

  task automatic push(input logic [7:0] d, input logic [9:0] e);
    int k;
    k = 0;
    char_in_valid <= 1'h1;
    char_in_data <= d;
    char_q.push_back(e);
    @(posedge ref_clk);
    while (char_in_ready !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    char_in_valid <= 1'h0;
    @(posedge ref_clk);
    if (k == 200) begin
      num_errors++;
      give_verdict();
    end
  endtask : push

  task automatic drain;
    for (int i = 0; i < 400 && char_q.size() != 0; i++) @(posedge ref_clk);
    if (char_q.size() != 0) begin
      num_errors++;
      give_verdict();
    end
  endtask : drain

  // results are compared in arrival order against notes left by the drivers
  always @(posedge ref_clk) begin
    if (!rst && (cfg_ack === 1'b1 || cfg_err === 1'b1)) begin
      cmp_lvl("cfg_ack", (resp_q.size() != 0) ? resp_q.pop_front() : 1'bx, cfg_ack);
    end
    if (!rst && char_valid === 1'b1 && char_ready === 1'b1) begin
      cmp_char((char_q.size() != 0) ? char_q.pop_front() : 10'hx, {char_port, char_data});
    end
  end

  initial begin
    {rst, two_port, cfg_wr, cfg_data8, cfg_rtu, cfg_stop2, transmit_block_req, msg_req, char_in_valid, hold, slow} = 11'h600;
    {dsr, cfg_port, cfg_parity, cfg_baud, cfg_addr, char_in_data} = 26'h0;
    op_mode = serial_cfg_pkg::OP_SINGLE;
    cfg_mode = serial_cfg_pkg::PM_MODBUS;
    void'($urandom(56481));
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (3) @(posedge ref_clk);
    cmp_lvl("pri_baud", 8'(serial_cfg_pkg::BAUD_9600), 8'(port_baud[0]));
    cmp_lvl("pri_par", 8'(serial_cfg_pkg::PAR_EVEN), 8'(port_parity[0]));
    cmp_lvl("modem", 8'h03, 8'(modem_en));
    cmp_lvl("pri_addr", 8'h01, port_addr[0]);
    cmp_lvl("exp_ascii", 8'h02, {6'h0, port_on[2], slave_resp[2]});
    $display("test defaults done");
    ra = 8'h01 + 8'($urandom % 247);
    cfg(2'h0, 3'h0, 4'ha, 1'h1, 1'h1, 2'h2, 1'h0, 8'h01, 1'h0);
    cfg(2'h0, 3'h0, 4'ha, 1'h0, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    cfg(2'h0, 3'h0, 4'he, 1'h1, 1'h1, 2'h1, 1'h0, 8'h01, 1'h0);
    cfg(2'h0, 3'h0, 4'he, 1'h1, 1'h1, 2'h2, 1'h1, 8'h01, 1'h0);
    cfg(2'h0, 3'h0, 4'he, 1'h1, 1'h1, 2'h2, 1'h0, 8'hf8, 1'h0);
    cfg(2'h0, 3'h0, 4'he, 1'h1, 1'h1, 2'h2, 1'h0, 8'hf7, 1'h1);
    cfg(2'h1, 3'h0, 4'h0, 1'h0, 1'h0, 2'h1, 1'h1, ra, 1'h1);
    cmp_lvl("sec_addr", ra, port_addr[1]);
    cfg(2'h1, 3'h1, 4'h7, 1'h1, 1'h0, 2'h2, 1'h0, 8'h01, 1'h0);
    cfg(2'h2, 3'h1, 4'hc, 1'h0, 1'h0, 2'h0, 1'h0, 8'h01, 1'h0);
    cfg(2'h2, 3'h1, 4'hc, 1'h1, 1'h0, 2'h2, 1'h1, 8'h01, 1'h0);
    cfg(2'h2, 3'h1, 4'hc, 1'h1, 1'h1, 2'h0, 1'h0, 8'h01, 1'h0);
    cfg(2'h2, 3'h1, 4'hf, 1'h0, 1'h0, 2'h2, 1'h0, 8'h01, 1'h0);
    cfg(2'h2, 3'h1, 4'hc, 1'h0, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    cfg(2'h2, 3'h3, 4'he, 1'h1, 1'h0, 2'h0, 1'h0, 8'h01, 1'h1);
    cfg(2'h1, 3'h1, 4'h0, 1'h1, 1'h0, 2'h2, 1'h0, 8'h01, 1'h0);
    cfg(2'h1, 3'h1, 4'h7, 1'h1, 1'h0, 2'h2, 1'h1, 8'h01, 1'h1);
    cfg(2'h3, 3'h0, 4'he, 1'h1, 1'h1, 2'h2, 1'h0, 8'h01, 1'h0);
    cmp_lvl("sec_frame", 8'h0e, {4'h0, port_data8[1], port_stop2[1], port_parity[1]});
    $display("test config done");
    slow <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      ra = 8'($urandom);
      push(ra, {2'h1, ra});
    end
    drain();
    hold <= 1'h1;
    n = 0;
    char_in_valid <= 1'h1;
    for (int i = 0; i < 40 && n == i; i++) begin
      char_in_data <= 8'(i);
      @(posedge ref_clk);
      if (char_in_ready === 1'b1) begin
        char_q.push_back({2'h1, 8'(i)});
        n++;
      end
    end
    char_in_valid <= 1'h0;
    cmp_lvl("refused", 8'h01, 8'(n >= 16 && n < 40));
    hold <= 1'h0;
    cfg(2'h1, 3'h1, 4'ha, 1'h0, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    drain();
    push(8'hc5, 10'h145);
    $display("test chars done");
    cfg(2'h1, 3'h2, 4'ha, 1'h1, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    push(8'hc5, 10'h1c5);
    cmp_lvl("sec_ascii", 8'h00, {6'h0, slave_resp[1], modem_en[1]});
    drain();
    dsr <= 2'h2;
    repeat (3) @(posedge ref_clk);
    cmp_lvl("sec_rtu", 8'h03, {6'h0, slave_resp[1], port_rtu[1]});
    cfg(2'h1, 3'h0, 4'ha, 1'h1, 1'h1, 2'h2, 1'h0, 8'h01, 1'h1);
    cfg(2'h0, 3'h2, 4'he, 1'h1, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    cmp_lvl("pri_modem", 8'h00, 8'(modem_en[0]));
    $display("test toggle done");
    transmit_block_req <= 1'h1;
    msg_req <= 1'h1;
    repeat (3) @(posedge ref_clk);
    cmp_lvl("grant_both", 8'h02, {6'h0, transmit_block_grant, msg_grant});
    transmit_block_req <= 1'h0;
    repeat (3) @(posedge ref_clk);
    cmp_lvl("grant_msg", 8'h01, {6'h0, transmit_block_grant, msg_grant});
    $display("test grants done");
    op_mode <= serial_cfg_pkg::OP_PARENT;
    repeat (4) @(posedge ref_clk);
    cmp_lvl("parent_modem", 8'h01, 8'(modem_en));
    cmp_lvl("exp_baud", 8'(serial_cfg_pkg::EXP_PRESET_BAUD), 8'(port_baud[2]));
    cfg(2'h1, 3'h2, 4'ha, 1'h1, 1'h0, 2'h2, 1'h0, 8'h01, 1'h1);
    cfg(2'h2, 3'h1, 4'he, 1'h1, 1'h0, 2'h0, 1'h0, 8'h01, 1'h0);
    two_port <= 1'h0;
    op_mode <= serial_cfg_pkg::OP_CHILD;
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    cmp_lvl("child_one", 8'h00, {6'h0, port_on[1], modem_en[0]});
    $display("test modes done");
    for (int i = 0; i < 50 && resp_q.size() != 0; i++) @(posedge ref_clk);
    if (resp_q.size() != 0 || char_q.size() != 0) num_errors++;
    give_verdict();
  end
endmodule : serial_port_mode_config_tb
